// File: gpc_consts.svh
// Offsets, field positions, reset values and pipeline counts of the pin control block
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define GPC_ADDR_W          7
`define GPC_DATA_W          16
`define GPC_CTRL_OFFSET     7'h0D

// ****************************************************************
// Field positions of the control register
// ****************************************************************
`define GPC_DIR_BIT         15
`define GPC_PULL_HI         14
`define GPC_PULL_LO         13
`define GPC_MODE_BIT        12
`define GPC_POL_BIT         10
`define GPC_LVL_BIT         5
`define GPC_FN_HI           3
`define GPC_FN_LO           0

// ****************************************************************
// Reset values
// ****************************************************************
`define GPC_DIR_RST         1'h1
`define GPC_PULL_RST        2'h0
`define GPC_MODE_RST        1'h0
`define GPC_POL_RST         1'h0
`define GPC_LVL_RST         1'h0
`define GPC_FN_RST          4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define GPC_SYNC_STAGES     2

`endif

// File: gpc_pkg.sv
// Types shared by the pin control block
package gpc_pkg;

    // ****************************************************************
    // Pin function codes
    // ****************************************************************
    typedef enum logic [3:0] {
        GPC_FN_LOGIC_IN  = 4'h0,
        GPC_FN_EDGE_IN   = 4'h1,
        GPC_FN_CLK_OUT   = 4'h2,
        GPC_FN_IRQ_OUT   = 4'h3,
        GPC_FN_TEMP_OUT  = 4'h7,
        GPC_FN_DMIC_OUT  = 4'h9,
        GPC_FN_LEVEL_OUT = 4'hA,
        GPC_FN_UV_OUT    = 4'hB
    } gpc_fn_t;

    // Pull select encodings
    typedef enum logic [1:0] {
        GPC_PULL_NONE = 2'h0,
        GPC_PULL_DOWN = 2'h1,
        GPC_PULL_UP   = 2'h2,
        GPC_PULL_RSVD = 2'h3
    } gpc_pull_t;

    // ****************************************************************
    // Stored control fields
    // ****************************************************************
    typedef struct packed {
        logic       pinDirection;
        logic [1:0] pinPullSelect;
        logic       pinIrqEdgeMode;
        logic       pinPolarityInvert;
        logic       pinLevel;
        logic [3:0] pinFunctionSelect;
    } gpc_ctrl_t;

    // Internal signals that may be routed to the pin
    typedef struct packed {
        logic clockOutSignal;
        logic irqRequest;
        logic overTempFlag;
        logic digitalMicClock;
        logic regulatorUndervoltageFlag;
    } gpc_srcs_t;

    // Pad controls
    typedef struct packed {
        logic pullUpEn;
        logic pullDownEn;
    } gpc_pad_t;

endpackage

// File: gpc_pin_sync.sv
// Two-stage synchroniser for the pin input with edge detection after it
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_pin_sync (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic rawIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    // ****************************************************************
    // Synchroniser chain
    // ****************************************************************
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    always_comb begin
        meta_d = rawIn;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'h0;
            sync_q <= 1'h0;
            prev_q <= 1'h0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Edges only look at settled stages, never at the first flop
    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule // gpc_pin_sync

// File: gpc_pin_control.sv
// Control register and pin logic for general pin one
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_pin_control #(
    parameter int ADDR_W = `GPC_ADDR_W,
    parameter int DATA_W = `GPC_DATA_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    // Register port from the device control interface
    input  wire logic                 regWrEn,
    input  wire logic                 regRdEn,
    input  wire logic [ADDR_W-1:0]    regAddr,
    input  wire logic [DATA_W-1:0]    regWrData,
    output logic      [DATA_W-1:0]    regRdData,
    output logic                      regRdValid,
    // Internal sources that may be routed to the pin
    input  wire gpc_pkg::gpc_srcs_t   srcs,
    // Pin
    input  wire logic                 pinIn,
    output logic                      pinOut,
    output logic                      pinOe,
    output gpc_pkg::gpc_pad_t         pad,
    // Edge-detection event towards the interrupt status logic
    output logic                      pinEdgeEvent
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ADDR_W < `GPC_ADDR_W) begin : g_bad_addr
        $error("ADDR_W too narrow for the control register offset");
    end
    if (DATA_W != `GPC_DATA_W) begin : g_bad_data
        $error("DATA_W must match the 16-bit control register");
    end

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // True for every function code that puts a signal on the pin
    function automatic logic isOutputFn(input logic [3:0] fn);
        case (fn)
            gpc_pkg::GPC_FN_CLK_OUT,
            gpc_pkg::GPC_FN_IRQ_OUT,
            gpc_pkg::GPC_FN_TEMP_OUT,
            gpc_pkg::GPC_FN_DMIC_OUT,
            gpc_pkg::GPC_FN_LEVEL_OUT,
            gpc_pkg::GPC_FN_UV_OUT: isOutputFn = 1'h1;
            default:                isOutputFn = 1'h0;
        endcase
    endfunction

    // Unpacks a write word into the stored fields
    function automatic gpc_pkg::gpc_ctrl_t unpackCtrl(input logic [DATA_W-1:0] w);
        gpc_pkg::gpc_ctrl_t c;
        c.pinDirection      = w[`GPC_DIR_BIT];
        c.pinPullSelect     = w[`GPC_PULL_HI:`GPC_PULL_LO];
        c.pinIrqEdgeMode    = w[`GPC_MODE_BIT];
        c.pinPolarityInvert = w[`GPC_POL_BIT];
        c.pinLevel          = w[`GPC_LVL_BIT];
        c.pinFunctionSelect = w[`GPC_FN_HI:`GPC_FN_LO];
        unpackCtrl = c;
    endfunction

    // ****************************************************************
    // Pin input sampling
    // ****************************************************************
    logic pinLevelSync;
    logic pinRise;
    logic pinFall;

    gpc_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .rawIn   (pinIn),
        .level   (pinLevelSync),
        .rise    (pinRise),
        .fall    (pinFall)
    );

    // ****************************************************************
    // Control register
    // ****************************************************************
    gpc_pkg::gpc_ctrl_t ctrl_q;
    gpc_pkg::gpc_ctrl_t ctrl_d;
    logic               ctrlHit;

    assign ctrlHit = (regAddr[`GPC_ADDR_W-1:0] == `GPC_CTRL_OFFSET);

    always_comb begin
        ctrl_d = ctrl_q;
        if (regWrEn && ctrlHit) begin
            ctrl_d = unpackCtrl(regWrData);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q.pinDirection      <= `GPC_DIR_RST;
            ctrl_q.pinPullSelect     <= `GPC_PULL_RST;
            ctrl_q.pinIrqEdgeMode    <= `GPC_MODE_RST;
            ctrl_q.pinPolarityInvert <= `GPC_POL_RST;
            ctrl_q.pinLevel          <= `GPC_LVL_RST;
            ctrl_q.pinFunctionSelect <= `GPC_FN_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ****************************************************************
    // Register read path
    // ****************************************************************
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    logic              rdValid_q;
    logic              rdValid_d;

    always_comb begin
        rdData_d  = rdData_q;
        rdValid_d = regRdEn;
        if (regRdEn) begin
            // Unmapped addresses and reserved bits read as zero
            rdData_d = '0;
            if (ctrlHit) begin
                rdData_d[`GPC_DIR_BIT]                = ctrl_q.pinDirection;
                rdData_d[`GPC_PULL_HI:`GPC_PULL_LO]   = ctrl_q.pinPullSelect;
                rdData_d[`GPC_MODE_BIT]               = ctrl_q.pinIrqEdgeMode;
                rdData_d[`GPC_POL_BIT]                = ctrl_q.pinPolarityInvert;
                // Reads show the pin, not the written value
                rdData_d[`GPC_LVL_BIT]                =
                    pinLevelSync ^ ctrl_q.pinPolarityInvert;
                rdData_d[`GPC_FN_HI:`GPC_FN_LO]       = ctrl_q.pinFunctionSelect;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q  <= '0;
            rdValid_q <= 1'h0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign regRdData  = rdData_q;
    assign regRdValid = rdValid_q;

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    logic     pinOut_q;
    logic     pinOut_d;
    logic     pinOe_q;
    logic     pinOe_d;
    gpc_pkg::gpc_pad_t pad_q;
    gpc_pkg::gpc_pad_t pad_d;
    logic     srcSel;

    always_comb begin
        case (ctrl_q.pinFunctionSelect)
            gpc_pkg::GPC_FN_LEVEL_OUT: srcSel = ctrl_q.pinLevel;
            gpc_pkg::GPC_FN_CLK_OUT:   srcSel = srcs.clockOutSignal;
            gpc_pkg::GPC_FN_IRQ_OUT:   srcSel = srcs.irqRequest;
            gpc_pkg::GPC_FN_TEMP_OUT:  srcSel = srcs.overTempFlag;
            gpc_pkg::GPC_FN_DMIC_OUT:  srcSel = srcs.digitalMicClock;
            gpc_pkg::GPC_FN_UV_OUT:    srcSel = srcs.regulatorUndervoltageFlag;
            default:                   srcSel = 1'h0;
        endcase
        // Polarity applies to every driven value so inverted flags stay consistent
        pinOut_d = srcSel ^ ctrl_q.pinPolarityInvert;
        // Drive only with an output direction and a real output function
        pinOe_d  = ~ctrl_q.pinDirection
                   & isOutputFn(ctrl_q.pinFunctionSelect);
        pad_d.pullUpEn   = (ctrl_q.pinPullSelect == gpc_pkg::GPC_PULL_UP);
        pad_d.pullDownEn = (ctrl_q.pinPullSelect == gpc_pkg::GPC_PULL_DOWN);
    end

    // The registered drive adds one cycle to routed clocks; they are slow enough
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinOut_q <= 1'h0;
            pinOe_q  <= 1'h0;
            pad_q    <= '0;
        end else begin
            pinOut_q <= pinOut_d;
            pinOe_q  <= pinOe_d;
            pad_q    <= pad_d;
        end
    end

    assign pinOut = pinOut_q;
    assign pinOe  = pinOe_q;
    assign pad    = pad_q;

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    logic evt_q;
    logic evt_d;
    logic edgeHit;

    always_comb begin
        // Raw pin edges are used so a polarity change never fakes an edge
        if (ctrl_q.pinIrqEdgeMode) begin
            edgeHit = pinRise | pinFall;
        end else if (ctrl_q.pinPolarityInvert) begin
            edgeHit = pinFall;
        end else begin
            edgeHit = pinRise;
        end
        evt_d = edgeHit
                & (ctrl_q.pinFunctionSelect == gpc_pkg::GPC_FN_EDGE_IN);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evt_q <= 1'h0;
        end else begin
            evt_q <= evt_d;
        end
    end

    assign pinEdgeEvent = evt_q;

endmodule // gpc_pin_control

// File: gpc_pin_control_sva.sv
// Assertion checker for the pin control block
`timescale 1ns/1ps
`include "gpc_consts.svh"
module gpc_pin_control_sva #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 16
) (
    input wire logic               ref_clk,
    input wire logic               rstn,
    input wire logic               regWrEn,
    input wire logic               regRdEn,
    input wire logic [ADDR_W-1:0]  regAddr,
    input wire logic [DATA_W-1:0]  regWrData,
    input wire logic [DATA_W-1:0]  regRdData,
    input wire logic               regRdValid,
    input wire gpc_pkg::gpc_srcs_t srcs,
    input wire logic               pinIn,
    input wire logic               pinOut,
    input wire logic               pinOe,
    input wire gpc_pkg::gpc_pad_t  pad,
    input wire logic               pinEdgeEvent
);
    logic [15:0] ctrlMirror_q;
    logic [15:0] ctrlMirror_d;
    logic        srcSel;
    logic        oeExp;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ****
    // Shadow of the stored fields
    // ****
    always_comb begin
        ctrlMirror_d = ctrlMirror_q;
        if (regWrEn && regAddr == `GPC_CTRL_OFFSET) begin
            ctrlMirror_d = regWrData & 16'hF42F;
        end
        case (ctrlMirror_q[3:0])
            4'h2: srcSel = srcs.clockOutSignal;
            4'h3: srcSel = srcs.irqRequest;
            4'h7: srcSel = srcs.overTempFlag;
            4'h9: srcSel = srcs.digitalMicClock;
            4'hA: srcSel = ctrlMirror_q[5];
            4'hB: srcSel = srcs.regulatorUndervoltageFlag;
            default: srcSel = 1'b0;
        endcase
        oeExp = ~ctrlMirror_q[15] & (ctrlMirror_q[3:0] inside {4'h2, 4'h3, 4'h7, 4'h9, 4'hA, 4'hB});
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) ctrlMirror_q <= 16'h8000;
        else ctrlMirror_q <= ctrlMirror_d;
    end
    AST_PULL: assert property (pad == $past({ctrlMirror_q[14:13] == 2'h2,
        ctrlMirror_q[14:13] == 2'h1})) else $error("pull enables wrong");
    AST_OE: assert property (pinOe == $past(oeExp))
        else $error("output enable wrong");
    AST_OUT: assert property (pinOe |-> pinOut == $past(srcSel ^ ctrlMirror_q[10]))
        else $error("driven level wrong");
    AST_RD_VALID: assert property (regRdValid == $past(regRdEn))
        else $error("read valid timing wrong");
    AST_RD_OTHER: assert property (regRdEn && regAddr != `GPC_CTRL_OFFSET |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    AST_RD_FIELDS: assert property (regRdEn && regAddr == `GPC_CTRL_OFFSET |=>
        (regRdData & 16'hFFDF) == ($past(ctrlMirror_q) & 16'hF40F)) else $error("fields wrong");
    AST_RD_LEVEL: assert property (regRdEn && regAddr == `GPC_CTRL_OFFSET |=>
        regRdData[5] == ($past(pinIn, 3) ^ $past(ctrlMirror_q[10]))) else $error("level wrong");
    AST_EDGE: assert property (pinEdgeEvent == ($past(ctrlMirror_q[3:0]) == 4'h1 &&
        ($past(ctrlMirror_q[12]) ? $past(pinIn, 3) != $past(pinIn, 4) :
        $past(pinIn, 3) != $past(ctrlMirror_q[10]) && $past(pinIn, 4) == $past(ctrlMirror_q[10]))))
        else $error("edge event wrong");
endmodule // gpc_pin_control_sva

bind gpc_pin_control gpc_pin_control_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
    .ref_clk(ref_clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .srcs(srcs),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pad(pad), .pinEdgeEvent(pinEdgeEvent));

// File: gpc_ext_circuit.sv
// External circuit model on the pin
`timescale 1ns/1ps
module gpc_ext_circuit (
    input wire logic              ref_clk,
    input wire logic              pinOut,
    input wire logic              pinOe,
    input wire gpc_pkg::gpc_pad_t pad,
    input wire logic              extDrive,
    input wire logic              extLevel,
    output logic                  pinIn
);
    // A floating pin toggles so that no stale level can pass for a real one
    logic floatLevel_q = 1'b0;
    always_ff @(posedge ref_clk) floatLevel_q <= ~floatLevel_q;
    always_comb begin
        if (pinOe) pinIn = pinOut;
        else if (extDrive) pinIn = extLevel;
        else if (pad.pullUpEn) pinIn = 1'b1;
        else if (pad.pullDownEn) pinIn = 1'b0;
        else pinIn = floatLevel_q;
    end
endmodule // gpc_ext_circuit

// File: test_gpio_pin_control.sv
// Self-checking testbench for the pin control block
`timescale 1ns/1ps
`include "gpc_consts.svh"
module test_gpio_pin_control;
    logic               ref_clk = 1'b0;
    logic               rstn = 1'b0;
    logic               regWrEn = 1'b0;
    logic               regRdEn = 1'b0;
    logic [6:0]         regAddr = 7'h00;
    logic [15:0]        regWrData = 16'h0000;
    logic [15:0]        regRdData;
    logic               regRdValid;
    gpc_pkg::gpc_srcs_t srcs = 5'h00;
    logic               pinIn;
    logic               pinOut;
    logic               pinOe;
    logic               pinEdgeEvent;
    gpc_pkg::gpc_pad_t  pad;
    logic               extDrive = 1'b1;
    logic               extLevel = 1'b0;
    logic [15:0]        expQ[$];
    logic [15:0]        cfg[4] = '{16'h8001, 16'h8401, 16'h9001, 16'h9000};
    logic [1:0]         evExp[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int                 fails = 0;
    int                 checked = 0;
    int                 evCount = 0;
    int                 base;
    logic               sel;
    logic               oeExp;
    logic               lvl;

    always #5 ref_clk = ~ref_clk;

    gpc_pin_control uut (.ref_clk(ref_clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .srcs(srcs), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pad(pad),
        .pinEdgeEvent(pinEdgeEvent));
    gpc_ext_circuit ext (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe), .pad(pad),
        .extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_rd(input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value regRdData expected %h seen %h", exp, got);
        end
    endtask
    task automatic cmp_pin(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= `GPC_CTRL_OFFSET;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRdEn <= 1'b0;
    endtask

    // Each answered read is matched against the oldest expectation
    always @(posedge ref_clk) begin
        if (pinEdgeEvent === 1'b1) evCount++;
        if (regRdValid === 1'b1) begin
            cmp_rd(expQ.size() > 0 ? expQ.pop_front() : 16'hXXXX, regRdData);
        end
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h2F7209CE));
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`GPC_CTRL_OFFSET, 16'h8000);
        rd(7'h0E, 16'h0000);
        @(negedge ref_clk);
        cmp_pin("pad", 16'h0000, {14'h0000, pad});
        cmp_pin("pinOe", 16'h0000, {15'h0000, pinOe});
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            @(posedge ref_clk);
            extDrive <= (p == 0 || p == 3);
            extLevel <= 1'b1;
            wr({1'b1, 2'(p), 13'h0000});
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            cmp_pin("pad", {14'h0000, p == 2, p == 1}, {14'h0000, pad});
            rd(`GPC_CTRL_OFFSET, {1'b1, 2'(p), 7'h00, p != 1, 5'h00});
        end
        $display("test pull done");
        extDrive <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            // Sources are design inputs, so they only move on a rising edge
            @(posedge ref_clk);
            srcs <= 5'($urandom);
            lvl = 1'($urandom);
            wr({5'h00, i[4], 4'h0, lvl, 1'b0, i[3:0]});
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            oeExp = 1'b1;
            case (i[3:0])
                4'h2: sel = srcs.clockOutSignal;
                4'h3: sel = srcs.irqRequest;
                4'h7: sel = srcs.overTempFlag;
                4'h9: sel = srcs.digitalMicClock;
                4'hA: sel = lvl;
                4'hB: sel = srcs.regulatorUndervoltageFlag;
                default: oeExp = 1'b0;
            endcase
            cmp_pin("pinOe", {15'h0000, oeExp}, {15'h0000, pinOe});
            if (oeExp) begin
                cmp_pin("pinOut", {15'h0000, sel ^ i[4]}, {15'h0000, pinOut});
                rd(`GPC_CTRL_OFFSET, {5'h00, i[4], 4'h0, sel, 1'b0, i[3:0]});
            end
        end
        wr(16'h802A);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_pin("pinOe", 16'h0000, {15'h0000, pinOe});
        $display("test functions done");
        extDrive <= 1'b1;
        extLevel <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(cfg[k]);
            repeat (6) @(posedge ref_clk);
            for (int e = 0; e < 2; e++) begin
                @(negedge ref_clk);
                base = evCount;
                @(posedge ref_clk);
                extLevel <= ~extLevel;
                repeat (6) @(posedge ref_clk);
                @(negedge ref_clk);
                cmp_pin("edge count", {15'h0000, evExp[k][e]}, 16'(evCount - base));
            end
        end
        $display("test edges done");
        end_of_test();
    end
endmodule // test_gpio_pin_control
